/* File: src/adc_backend_pkg.sv */
// Shared constants for the converter back end and its controlling host
package adc_backend_pkg;
    // Data path
    localparam int CH_COUNT       = 4;
    localparam int SAMPLE_W       = 14;
    localparam int FLAG_LATENCY   = 6;
    localparam int TRIP_SHIFT     = 3;          // Divide by 8
    localparam logic [13:0] FULL_SCALE = 14'h1fff;
    localparam int FIR_TAPS       = 7;
    localparam int FIR_SHIFT      = 5;

    // Serial register port of the device
    localparam int SER_FRAME_BITS = 16;
    localparam logic [7:0] SREG_TRIP   = 8'h00;
    localparam logic [7:0] SREG_EXTEND = 8'h01;
    localparam logic [7:0] SREG_DECIM  = 8'h02;
    localparam logic [2:0] TRIP_RESET   = 3'h7;
    localparam logic [1:0] EXTEND_RESET = 2'h0;
    localparam logic [1:0] DECIM_RESET  = 2'h0;
    localparam int DECIM_EN_BIT   = 0;
    localparam int DECIM_HP_BIT   = 1;

    // Host timing at the 25 MHz clock
    localparam int CLK_PERIOD_NS       = 40;
    localparam int POWER_ON_DELAY_NS   = 3000000;
    localparam int RESET_PULSE_NS      = 20;
    localparam int REG_WRITE_DELAY_NS  = 100;
    localparam int POWER_ON_CYCLES     = (POWER_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYCLES  = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REG_WRITE_CYCLES    = (REG_WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_DIV            = 2;

    // Host register map, byte addresses
    localparam logic [4:0] HREG_CTRL     = 5'h00;
    localparam logic [4:0] HREG_CMD      = 5'h04;
    localparam logic [4:0] HREG_STATUS   = 5'h08;
    localparam logic [4:0] HREG_IRQ_STAT = 5'h0c;
    localparam logic [4:0] HREG_IRQ_MASK = 5'h10;
    localparam int IRQ_W          = 5;
    localparam int IRQ_DONE_BIT   = 4;

    typedef enum logic [2:0] {
        ST_POWER  = 3'b000,
        ST_RST    = 3'b001,
        ST_SETTLE = 3'b010,
        ST_IDLE   = 3'b011,
        ST_SHIFT  = 3'b100
    } host_state_t;
endpackage

/* File: src/adc_link_if.sv */
// Pins between the converter back end and its controlling host
`timescale 1ns/1ns
interface adc_link_if;
    logic hw_reset_n;
    logic serial_port_enable_n;
    logic serial_clk;
    logic serial_data;
    logic overrange_flag_ch_a;
    logic overrange_flag_ch_b;
    logic overrange_flag_ch_c;
    logic overrange_flag_ch_d;

    modport dev (
        input  hw_reset_n, serial_port_enable_n, serial_clk, serial_data,
        output overrange_flag_ch_a, overrange_flag_ch_b, overrange_flag_ch_c,
               overrange_flag_ch_d
    );
    modport host (
        output hw_reset_n, serial_port_enable_n, serial_clk, serial_data,
        input  overrange_flag_ch_a, overrange_flag_ch_b, overrange_flag_ch_c,
               overrange_flag_ch_d
    );
endinterface

/* File: src/converter_backend.sv */
// Converter back end: decimate-by-2 filters and fast over-range flags
//
// How it works
// - One dedicated over-range flag per channel
// - Flag rises six clocks after offending sample
// - Trip level is full scale times field/8
// - Trip field resets to seven
// - Serial writes change trip level for later samples
// - Per-channel decimate-by-2, low- or high-pass
// - Half-band filter, about 41% pass band
// - Host waits 3 ms before reset pulse
// - Host holds reset low at least 20 ns
// - Host waits 100 ns before serial enable
// - Flag may stretch one, two or four clocks
// - Low hardware reset restores register defaults
`timescale 1ns/1ns
module converter_backend
    import adc_backend_pkg::*;
#(
    parameter int CH = CH_COUNT,
    parameter int W  = SAMPLE_W
) (
    input  wire logic              clk_in,          // Sample clock
    input  wire logic              rst_n_in,        // Sync reset, active low
    input  wire logic [CH*W-1:0]   sample_in,       // Signed samples, channel 0 low
    output logic      [CH*W-1:0]   data_out,        // Filtered or raw samples
    output logic                   data_valid_out,  // Pulse per output sample
    adc_link_if.dev                link             // Pins to the host
);
    localparam int ACC_W = W + 7;

    logic [2:0]         trip_q;
    logic [1:0]         extend_q;
    logic [1:0]         decim_q;

    logic               sclk_prev_q;
    logic [3:0]         bit_cnt_q;
    logic [SER_FRAME_BITS-2:0] shift_q;

    logic               phase_q;
    logic [CH-1:0]      flag_q;

    logic [2:0]         extend_len;
    logic               cfg_rst;
    logic               sclk_rise;
    logic [SER_FRAME_BITS-1:0] frame;

    // Pin reset acts as a level, not an edge
    assign cfg_rst   = !rst_n_in || !link.hw_reset_n;
    assign sclk_rise = link.serial_clk && !sclk_prev_q;
    assign frame     = {shift_q, link.serial_data};

    always_comb
    begin
        // Code 3 stretches by four
        unique case (extend_q)
            2'h0: extend_len = 3'h0;
            2'h1: extend_len = 3'h1;
            2'h2: extend_len = 3'h2;
            2'h3: extend_len = 3'h4;
        endcase
    end

    // Serial receiver: 8-bit address then 8-bit data, MSB first
    always_ff @(posedge clk_in)
    begin
        if (cfg_rst)
        begin
            sclk_prev_q <= 1'b0;
            bit_cnt_q   <= 4'h0;
            shift_q     <= '0;
        end
        else
        begin
            sclk_prev_q <= link.serial_clk;
            // Enable high drops a part frame
            if (link.serial_port_enable_n)
                bit_cnt_q <= 4'h0;
            else if (sclk_rise)
            begin
                shift_q   <= frame[SER_FRAME_BITS-2:0];
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_in)
    begin
        if (cfg_rst)
        begin
            trip_q   <= TRIP_RESET;
            extend_q <= EXTEND_RESET;
            decim_q  <= DECIM_RESET;
        end
        else if (!link.serial_port_enable_n && sclk_rise
                 && bit_cnt_q == 4'(SER_FRAME_BITS - 1))
        begin
            // Unknown addresses are ignored
            unique case (frame[15:8])
                SREG_TRIP:   trip_q   <= frame[2:0];
                SREG_EXTEND: extend_q <= frame[1:0];
                SREG_DECIM:  decim_q  <= frame[1:0];
                default:     ;
            endcase
        end
    end

    // Shared even/odd sample phase for decimation and high-pass mixing
    always_ff @(posedge clk_in)
    begin
        if (cfg_rst)
        begin
            phase_q        <= 1'b0;
            data_valid_out <= 1'b0;
        end
        else
        begin
            // Free-running, so alignment is not fixed
            phase_q        <= !phase_q;
            data_valid_out <= decim_q[DECIM_EN_BIT] ? phase_q : 1'b1;
        end
    end

    // One filter and flag slice per channel
    genvar c;
    generate
        for (c = 0; c < CH; c++)
        begin : g_ch
            logic signed [W-1:0]   smp;
            logic signed [W:0]     mixed;

            logic signed [W:0]     taps_q [FIR_TAPS];
            logic signed [ACC_W-1:0] acc;

            logic [W:0]            mag;
            logic [W+2:0]          lhs;
            logic [W+2:0]          rhs;

            logic [FLAG_LATENCY-2:0] pipe_q;
            logic [2:0]            hold_q;

            assign smp = sample_in[c*W +: W];
            // High-pass shifts the band by mixing with alternating sign
            assign mixed = (decim_q[DECIM_HP_BIT] && phase_q)
                         ? -(W+1)'(smp) : (W+1)'(smp);

            // Half-band coefficients -1 0 9 16 9 0 -1 over 32
            assign acc = ACC_W'(taps_q[2]) * ACC_W'(9)
                       + ACC_W'(taps_q[4]) * ACC_W'(9)
                       + (ACC_W'(taps_q[3]) <<< 4)
                       - ACC_W'(taps_q[0]) - ACC_W'(taps_q[6]);

            always_ff @(posedge clk_in)
            begin
                if (cfg_rst)
                begin
                    for (int t = 0; t < FIR_TAPS; t++)
                        taps_q[t] <= '0;
                    data_out[c*W +: W] <= '0;
                end
                else
                begin
                    taps_q[0] <= mixed;
                    for (int t = 1; t < FIR_TAPS; t++)
                        taps_q[t] <= taps_q[t-1];
                    if (!decim_q[DECIM_EN_BIT])
                        data_out[c*W +: W] <= smp;
                    else if (phase_q)
                        data_out[c*W +: W] <= W'(acc >>> FIR_SHIFT);
                end
            end

            // Magnitude times 8 against full scale times field
            assign mag = smp[W-1] ? (W+1)'(-(W+1)'(smp)) : (W+1)'(smp);
            assign lhs = (W+3)'({mag, 3'h0});
            assign rhs = (W+3)'(FULL_SCALE) * (W+3)'(trip_q);

            always_ff @(posedge clk_in)
            begin
                if (cfg_rst)
                begin
                    pipe_q    <= '0;
                    hold_q    <= 3'h0;
                    flag_q[c] <= 1'b0;
                end
                else
                begin
                    // Five stages plus the output flop give six clocks
                    pipe_q <= {pipe_q[FLAG_LATENCY-3:0], lhs > rhs};
                    // A repeat hit reloads the full stretch
                    if (pipe_q[FLAG_LATENCY-2])
                        hold_q <= extend_len;
                    else if (hold_q != 3'h0)
                        hold_q <= hold_q - 3'h1;
                    flag_q[c] <= pipe_q[FLAG_LATENCY-2] || hold_q != 3'h0;
                end
            end
        end
    endgenerate

    // Flags come straight from flip-flops
    assign link.overrange_flag_ch_a = flag_q[0];
    assign link.overrange_flag_ch_b = flag_q[1];
    assign link.overrange_flag_ch_c = flag_q[2];
    assign link.overrange_flag_ch_d = flag_q[3];
endmodule

/* File: src/converter_host.sv */
// Controlling host: reset sequencing, serial register writes, flag capture
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
module converter_host
    import adc_backend_pkg::*;
#(
    parameter int POWER_CYCLES = POWER_ON_CYCLES
) (
    input  wire logic        clk_in,          // 25 MHz clock
    input  wire logic        rst_n_in,        // Sync reset, active low
    input  wire logic [4:0]  address_in,      // Avalon byte address
    input  wire logic        read_in,         // Avalon read
    input  wire logic        write_in,        // Avalon write
    input  wire logic [31:0] writedata_in,    // Avalon write data
    output logic      [31:0] readdata_out,    // Avalon read data
    output logic             waitrequest_out, // Avalon wait, high when idle
    output logic             irq_out,         // Level interrupt
    adc_link_if.host         link             // Pins to the device
);
    host_state_t         state_q;
    logic [16:0]         cnt_q;
    logic [3:0]          bit_q;
    logic [15:0]         frame_q;
    logic                tick_q;
    logic                rst_req_q;
    logic                cmd_req_q;
    logic [IRQ_W-1:0]    irq_stat_q;
    logic [IRQ_W-1:0]    irq_mask_q;
    logic [3:0]          flags_prev_q;
    logic [3:0]          flags;
    logic                done_pulse;
    logic                take;

    assign flags = {link.overrange_flag_ch_d, link.overrange_flag_ch_c,
                    link.overrange_flag_ch_b, link.overrange_flag_ch_a};
    assign take  = (read_in || write_in) && !waitrequest_out;
    assign done_pulse = state_q == ST_SHIFT && tick_q && link.serial_clk
                        && bit_q == 4'(SER_FRAME_BITS - 1);

    // One wait cycle, then the access completes
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            waitrequest_out <= 1'b1;
            readdata_out    <= 32'h0;
        end
        else
        begin
            waitrequest_out <= !((read_in || write_in) && waitrequest_out);
            if (read_in && waitrequest_out)
            begin
                unique case (address_in)
                    HREG_STATUS:   readdata_out <= {24'h0, flags, 1'b0,
                                       state_q == ST_SHIFT, state_q == ST_IDLE,
                                       state_q != ST_POWER};
                    HREG_IRQ_STAT: readdata_out <= 32'(irq_stat_q);
                    HREG_IRQ_MASK: readdata_out <= 32'(irq_mask_q);
                    default:       readdata_out <= 32'h0;
                endcase
            end
        end
    end

    // Requests wait until the sequencer is idle; a command written while one is pending or shifting is dropped
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rst_req_q  <= 1'b0;
            cmd_req_q  <= 1'b0;
            frame_q    <= 16'h0;
            irq_mask_q <= '0;
        end
        else
        begin
            if (take && write_in && address_in == HREG_CTRL && writedata_in[0])
                rst_req_q <= 1'b1;
            else if (state_q == ST_RST)
                rst_req_q <= 1'b0;
            if (take && write_in && address_in == HREG_CMD && !cmd_req_q
                && state_q != ST_SHIFT)
            begin
                cmd_req_q <= 1'b1;
                frame_q   <= writedata_in[15:0];
            end
            else if (state_q == ST_SHIFT)
                cmd_req_q <= 1'b0;
            if (take && write_in && address_in == HREG_IRQ_MASK)
                irq_mask_q <= writedata_in[IRQ_W-1:0];
        end
    end

    // Sticky events: set wins over write-one-to-clear
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            irq_stat_q   <= '0;
            flags_prev_q <= 4'h0;
            irq_out      <= 1'b0;
        end
        else
        begin
            flags_prev_q <= flags;
            irq_stat_q <= (irq_stat_q & ~((take && write_in && address_in == HREG_IRQ_STAT)
                          ? writedata_in[IRQ_W-1:0] : {IRQ_W{1'b0}}))
                          | {done_pulse, flags & ~flags_prev_q};
            irq_out <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Reset sequence and serial shifter
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q                   <= ST_POWER;
            cnt_q                     <= 17'h0;
            bit_q                     <= 4'h0;
            tick_q                    <= 1'b0;
            link.hw_reset_n           <= 1'b1;
            link.serial_port_enable_n <= 1'b1;
            link.serial_clk           <= 1'b0;
            link.serial_data          <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_q + 17'h1;
            tick_q <= cnt_q[0];
            unique case (state_q)
                ST_POWER:
                    if (cnt_q == 17'(POWER_CYCLES - 1))
                    begin
                        state_q         <= ST_RST;
                        cnt_q           <= 17'h0;
                        link.hw_reset_n <= 1'b0;
                    end
                ST_RST:
                    if (cnt_q == 17'(RESET_PULSE_CYCLES - 1))
                    begin
                        state_q         <= ST_SETTLE;
                        cnt_q           <= 17'h0;
                        link.hw_reset_n <= 1'b1;
                    end
                ST_SETTLE:
                    if (cnt_q == 17'(REG_WRITE_CYCLES - 1))
                        state_q <= ST_IDLE;
                ST_IDLE:
                    if (rst_req_q)
                    begin
                        state_q         <= ST_RST;
                        cnt_q           <= 17'h0;
                        link.hw_reset_n <= 1'b0;
                    end
                    else if (cmd_req_q)
                    begin
                        state_q                   <= ST_SHIFT;
                        cnt_q                     <= 17'h0;
                        bit_q                     <= 4'h0;
                        link.serial_port_enable_n <= 1'b0;
                        link.serial_data          <= frame_q[15];
                    end
                ST_SHIFT:
                    if (tick_q)
                    begin
                        link.serial_clk <= !link.serial_clk;
                        if (link.serial_clk)
                        begin
                            if (bit_q == 4'(SER_FRAME_BITS - 1))
                            begin
                                state_q                   <= ST_IDLE;
                                link.serial_port_enable_n <= 1'b1;
                            end
                            else
                            begin
                                bit_q            <= bit_q + 4'h1;
                                link.serial_data <= frame_q[4'hf - 4'(bit_q + 4'h1)];
                            end
                        end
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

/* File: test/adc_link_asserts.sv */
// Concurrent checks on the pins between the converter back end and its host
`timescale 1ns/1ns
module adc_link_asserts
    import adc_backend_pkg::*;
(
    input  wire logic                         clk_in,               // Shared clock
    input  wire logic                         rst_n_in,             // Sync reset, active low
    input  wire logic [CH_COUNT*SAMPLE_W-1:0] sample_in,            // Device samples
    input  wire logic                         hw_reset_n,           // Device reset pin
    input  wire logic                         serial_port_enable_n, // Serial frame enable
    input  wire logic                         serial_clk,           // Serial clock
    input  wire logic                         serial_data,          // Serial data
    input  wire logic                         overrange_flag_ch_a,  // Flag channel a
    input  wire logic                         overrange_flag_ch_b,  // Flag channel b
    input  wire logic                         overrange_flag_ch_c,  // Flag channel c
    input  wire logic                         overrange_flag_ch_d   // Flag channel d
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic [3:0] flags;
    logic [3:0] stale;
    logic [3:0] quiet_q [CH_COUNT];
    logic [4:0] bits_q;
    logic       sclk_q;

    assign flags = {overrange_flag_ch_d, overrange_flag_ch_c, overrange_flag_ch_b,
                    overrange_flag_ch_a};

    // Zero never trips, so 11 quiet samples outlast latency plus widest stretch
    always_ff @(posedge clk_in)
    begin
        for (int c = 0; c < CH_COUNT; c++)
        begin
            if (!rst_n_in || sample_in[c*SAMPLE_W +: SAMPLE_W] != '0)
                quiet_q[c] <= 4'h0;
            else if (quiet_q[c] != 4'hf)
                quiet_q[c] <= quiet_q[c] + 4'h1;
        end
    end

    always_comb
    begin
        for (int c = 0; c < CH_COUNT; c++)
            stale[c] = (quiet_q[c] >= 4'hb);
    end

    always_ff @(posedge clk_in)
    begin
        sclk_q <= rst_n_in ? serial_clk : 1'b0;
        if (!rst_n_in || serial_port_enable_n)
            bits_q <= 5'h00;
        else if (serial_clk && !sclk_q)
            bits_q <= bits_q + 5'h01;
    end

    sequence pulse_end_s;
        !hw_reset_n ##1 hw_reset_n;
    endsequence

    property trip_late_p(logic [SAMPLE_W-1:0] s, logic f);
        s == FULL_SCALE |-> ##6 f;
    endproperty

    trip_lat_a_a: assert property (trip_late_p(sample_in[13:0], overrange_flag_ch_a))
        else $error("flag a late after full scale sample");
    trip_lat_b_a: assert property (trip_late_p(sample_in[27:14], overrange_flag_ch_b))
        else $error("flag b late after full scale sample");
    trip_lat_c_a: assert property (trip_late_p(sample_in[41:28], overrange_flag_ch_c))
        else $error("flag c late after full scale sample");
    trip_lat_d_a: assert property (trip_late_p(sample_in[55:42], overrange_flag_ch_d))
        else $error("flag d late after full scale sample");
    flag_release_a: assert property ((flags & stale) == 4'h0)
        else $error("flag held after quiet input");
    pulse_width_a: assert property ($fell(hw_reset_n) |=> hw_reset_n)
        else $error("device reset pulse width wrong");
    settle_gap_a: assert property (pulse_end_s |-> serial_port_enable_n [*3])
        else $error("serial enable too soon after reset");
    sclk_framed_a: assert property ($rose(serial_clk) |-> !serial_port_enable_n)
        else $error("serial clock outside frame");
    sdata_steady_a: assert property ($rose(serial_clk) |-> $stable(serial_data))
        else $error("serial data moved at clock rise");
    frame_len_a: assert property ($rose(serial_port_enable_n) |-> bits_q == 5'h10)
        else $error("serial frame not sixteen bits");
endmodule

/* File: test/tb_top.sv */
// Bench joining the converter back end and its host over their pin interface
`timescale 1ns/1ns
`define CHECK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin mismatches++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top
    import adc_backend_pkg::*;
;
    localparam int POWER_CYC = 10;

    logic                         clk_in;
    logic                         rst_n_in;
    logic [CH_COUNT*SAMPLE_W-1:0] sample_in;
    logic [CH_COUNT*SAMPLE_W-1:0] data_out;
    logic                         data_valid_out;
    logic [4:0]                   address;
    logic                         read;
    logic                         write;
    logic [31:0]                  writedata;
    logic [31:0]                  readdata;
    logic [31:0]                  rd;
    logic                         waitrequest;
    logic                         irq;
    int                           mismatches;
    int                           n_tests;

    adc_link_if link_if ();
    wire logic [3:0] flags = {link_if.overrange_flag_ch_d, link_if.overrange_flag_ch_c,
                              link_if.overrange_flag_ch_b, link_if.overrange_flag_ch_a};

    converter_backend #(.CH(CH_COUNT), .W(SAMPLE_W)) converter_backend_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sample_in(sample_in), .data_out(data_out),
        .data_valid_out(data_valid_out), .link(link_if));
    converter_host #(.POWER_CYCLES(POWER_CYC)) converter_host_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .address_in(address), .read_in(read),
        .write_in(write), .writedata_in(writedata), .readdata_out(readdata),
        .waitrequest_out(waitrequest), .irq_out(irq), .link(link_if));
    adc_link_asserts adc_link_asserts_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sample_in(sample_in),
        .hw_reset_n(link_if.hw_reset_n), .serial_port_enable_n(link_if.serial_port_enable_n),
        .serial_clk(link_if.serial_clk), .serial_data(link_if.serial_data),
        .overrange_flag_ch_a(link_if.overrange_flag_ch_a),
        .overrange_flag_ch_b(link_if.overrange_flag_ch_b),
        .overrange_flag_ch_c(link_if.overrange_flag_ch_c),
        .overrange_flag_ch_d(link_if.overrange_flag_ch_d));

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task fail_wait(input string what);
        mismatches++;
        $display("ERROR %s expected done seen timeout", what);
        wrap_up();
    endtask

    // Request held until waitrequest is sampled low, data taken at that edge
    task bus(input logic [4:0] a, input logic wr, input logic [31:0] d);
        int i;
        @(posedge clk_in);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_in);
            if (waitrequest === 1'b0)
                break;
        end
        if (i == 20)
            fail_wait("bus answer");
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task rdchk(input logic [4:0] a, input logic [31:0] ex, input string nm);
        bus(a, 1'b0, 32'h0);
        `CHECK(nm, ex, rd)
    endtask

    task wait_idle;
        int i;
        for (i = 0; i < 100; i++)
        begin
            bus(HREG_STATUS, 1'b0, 32'h0);
            if (rd[1] === 1'b1)
                break;
        end
        if (i == 100)
            fail_wait("host idle");
    endtask

    // Done bit is cleared before and after so the interrupt test starts clean
    task dev_write(input logic [7:0] ra, input logic [7:0] rv);
        int i;
        bus(HREG_IRQ_STAT, 1'b1, 32'h10);
        bus(HREG_CMD, 1'b1, {16'h0, ra, rv});
        for (i = 0; i < 100; i++)
        begin
            bus(HREG_IRQ_STAT, 1'b0, 32'h0);
            if (rd[IRQ_DONE_BIT] === 1'b1)
                break;
        end
        if (i == 100)
            fail_wait("serial write");
        bus(HREG_IRQ_STAT, 1'b1, 32'h10);
    endtask

    // One sample on one channel, then the flag vector watched cycle by cycle
    task hit(input int ch, input logic [13:0] v, input logic hi, input int ext);
        int k;
        logic [3:0] ev;
        @(posedge clk_in);
        sample_in[ch*SAMPLE_W +: SAMPLE_W] <= v;
        for (k = 1; k <= 12; k++)
        begin
            @(posedge clk_in);
            if (k == 1)
                sample_in <= '0;
            #1;
            ev = (hi && k >= 6 && k <= 6 + ext) ? 4'h1 << ch : 4'h0;
            `CHECK("flags", ev, flags)
        end
    endtask

    task decim_check(input logic [13:0] ex);
        int k;
        int cnt;
        cnt = 0;
        repeat (20) @(posedge clk_in);
        for (k = 0; k < 8; k++)
        begin
            @(posedge clk_in);
            #1;
            if (data_valid_out === 1'b1)
            begin
                cnt++;
                `CHECK("decimated data", ex, data_out[13:0])
            end
        end
        `CHECK("valid count", 4, cnt)
    endtask

    initial
    begin
        int cyc;
        int lo;
        rst_n_in = 1'b0;
        sample_in = '0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        mismatches = 0;
        n_tests = 0;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (cyc = 0; cyc < 100; cyc++)
        begin
            @(posedge clk_in);
            if (link_if.hw_reset_n === 1'b0)
                break;
        end
        `CHECK("power wait", 1'b1, cyc >= POWER_CYC && cyc < 100)
        wait_idle();
        $display("Test power up done");

        for (int c = 0; c < CH_COUNT; c++)
            hit(c, 14'h1fff, 1'b1, 0);
        hit(0, 14'h1bff, 1'b0, 0);
        hit(0, 14'h1c00, 1'b1, 0);
        hit(2, 14'h2000, 1'b1, 0);
        for (int t = 1; t <= 6; t++)
        begin
            dev_write(SREG_TRIP, 8'(t));
            lo = (8191 * t) / 8;
            hit(3, 14'(lo), 1'b0, 0);
            hit(3, 14'(lo + 1), 1'b1, 0);
        end
        $display("Test thresholds done");

        for (int e = 1; e <= 3; e++)
        begin
            dev_write(SREG_EXTEND, 8'(e));
            hit(0, 14'h1fff, 1'b1, (e == 3) ? 4 : e);
        end
        $display("Test extension done");

        bus(HREG_IRQ_MASK, 1'b1, 32'h01);
        bus(HREG_IRQ_STAT, 1'b1, 32'h1f);
        rdchk(HREG_IRQ_MASK, 32'h01, "irq mask");
        hit(1, 14'h1fff, 1'b1, 4);
        `CHECK("irq masked", 1'b0, irq)
        rdchk(HREG_IRQ_STAT, 32'h02, "irq status");
        hit(0, 14'h1fff, 1'b1, 4);
        `CHECK("irq raised", 1'b1, irq)
        bus(HREG_IRQ_STAT, 1'b1, 32'h03);
        repeat (2) @(posedge clk_in);
        #1;
        `CHECK("irq cleared", 1'b0, irq)
        rdchk(5'h14, 32'h0, "unmapped read");
        $display("Test interrupts done");

        @(posedge clk_in);
        sample_in <= {4{14'h0064}};
        repeat (2) @(posedge clk_in);
        #1;
        `CHECK("bypass data", {4{14'h0064}}, data_out)
        `CHECK("bypass valid", 1'b1, data_valid_out)
        dev_write(SREG_DECIM, 8'h01);
        decim_check(14'h0064);
        dev_write(SREG_DECIM, 8'h03);
        decim_check(14'h0000);
        $display("Test decimation done");

        bus(HREG_CTRL, 1'b1, 32'h01);
        repeat (4) @(posedge clk_in);
        wait_idle();
        repeat (3) @(posedge clk_in);
        #1;
        `CHECK("valid after reset", 1'b1, data_valid_out)
        @(posedge clk_in);
        sample_in <= '0;
        repeat (12) @(posedge clk_in);
        hit(0, 14'h1bff, 1'b0, 0);
        hit(0, 14'h1c00, 1'b1, 0);
        $display("Test device reset done");
        wrap_up();
    end
endmodule
